/* File: shared/ascan_pkg.sv */
// constants and types of the antenna scan sequencer
//
// Contract
// - frequency priority dwells one frequency on each group antenna, then next
// - frequency priority is the default, active unless antenna priority chosen; code also runs it under antenna priority when the switch is off
// - first antenna follows the type of the first table frequency
// - frequencies follow table order, which also picks the group used
// - single master: master dwell first, then all members including master
// - after the last frequency the cycle restarts until stop or failure
// - every valid detection during a dwell is passed on for recording
// - preview works only when some group has a master designation
// - preview dwells one scan time on the group master only
// - detection in preview scans the whole group on that frequency
// - no detection in preview skips to the next frequency
// - group without master scans all antennas as frequency priority
// - whole-group master in preview selects all until a detection
// - preview is forced off while antenna priority is selected
// - preview command toggles preview enable
// - antenna priority dwells all frequencies of the antenna's group type on one antenna, then next
// - antenna priority visits frequencies in table order
// - antenna priority covers radio group first, then hydrophones master first
// - whole-group master dwell selects every port of the group together
// - priority command toggles frequency and antenna priority
// - one gain per switch port in port order plus front-panel gain
// - whole-group master gain applies to every member of the group
// - master code 0 whole group, 1 to 8 one port, 9 none
// - disabled frequencies are skipped in every mode
package ascan_pkg;
  localparam int NPORT = 8;
  localparam int NFREQ = 16;
  localparam logic [7:0] ADDR_MASK  = 8'hFC;
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_CFG   = 8'h08;
  localparam logic [7:0] ADDR_MAST  = 8'h0C;
  localparam logic [7:0] ADDR_STIME = 8'h10;
  localparam logic [7:0] ADDR_GCNT  = 8'h14;
  localparam logic [7:0] ADDR_ORD_R = 8'h18;
  localparam logic [7:0] ADDR_ORD_H = 8'h1C;
  localparam logic [7:0] ADDR_GN_LO = 8'h20;
  localparam logic [7:0] ADDR_GN_HI = 8'h24;
  localparam logic [7:0] ADDR_GN_X  = 8'h28;
  localparam logic [7:0] ADDR_FTAB  = 8'h2C;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_PRIO  = 2;
  localparam int CTRL_PREV  = 3;
  localparam int CFG_SW     = 0;
  localparam int CFG_CNT_LO = 1;
  localparam int CFG_CNT_HI = 5;
  localparam int FT_EN      = 0;
  localparam int FT_AC      = 1;
  localparam logic [3:0] MASTER_ALL  = 4'h0;
  localparam logic [3:0] MASTER_NONE = 4'h9;
  localparam logic [7:0] GAIN_RST    = 8'h32;
  localparam logic [15:0] STIME_RST  = 16'h000F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCAN_UNIT_NS  = 1000000;
  localparam int MS_CYCLES     = SCAN_UNIT_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_SETUP,
    ST_DWELL
  } ascan_state_type;
endpackage

/* File: design/ascan_dwell_timer.sv */
// dwell timer: millisecond prescaler and scan-time countdown
`timescale 1ns/100ps
module ascan_dwell_timer
  import ascan_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] ms_i,
  output logic             done_o
);
  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } ascan_tmr_type;

  ascan_tmr_type r;
  ascan_tmr_type n;

  // ==========================================================
  // countdown
  always_comb begin
    n = r;
    n.done = 1'b0;
    if (start_i) begin
      n.pre = '0;
      n.busy = 1'b1;
      n.cnt = (ms_i == '0) ? 16'h0001 : ms_i;
    end else if (r.busy) begin
      if (r.pre == 32'(TICK_CYCLES - 1)) begin
        n.pre = '0;
        n.cnt = r.cnt - 16'h0001;
        if (r.cnt == 16'h0001) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end else begin
        n.pre = r.pre + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done_o = r.done;
endmodule

/* File: design/ascan_sequencer.sv */
// antenna scan sequencer with its axi4-lite register file
`timescale 1ns/100ps
module ascan_sequencer
  import ascan_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  input  wire logic        det_valid_i,
  input  wire logic        mem_full_i,
  input  wire logic        power_fail_i,
  output logic [7:0]       switch_sel_o,
  output logic             front_panel_antenna_input_o,
  output logic [7:0]       gain_o,
  output logic [3:0]       freq_idx_o,
  output logic             dwell_o,
  output logic             record_o
);
  typedef struct packed {
    logic            aw_ok;
    logic            w_ok;
    logic [7:0]      waddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            use_sw;
    logic [4:0]      fcnt;
    logic [1:0][3:0] master;
    logic [15:0]     stime;
    logic [1:0][3:0] gcnt;
    logic [1:0][7:0][3:0] order;
    logic [7:0][7:0] pgain;
    logic [2:0][7:0] xgain;
    logic [15:0][1:0] ftab;
    logic            ant_prio;
    logic            prev_en;
    ascan_state_type st;
    logic [3:0]      fi;
    logic            g;
    logic            mstep;
    logic [2:0]      ap;
    logic            fresh;
    logic            det_seen;
    logic [7:0]      sel;
    logic            front;
    logic [7:0]      gain;
    logic [3:0]      fout;
    logic            dwell;
    logic            rec;
  } ascan_regs_type;

  ascan_regs_type r;
  ascan_regs_type n;
  logic           tmr_start;
  logic           tmr_done;

  // ==========================================================
  // helpers
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic has_master(input logic [3:0] code);
    return code != MASTER_NONE;
  endfunction

  function automatic logic [7:0] port_mask(input logic [3:0] code);
    logic [7:0] m;
    m = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (code == 4'(p + 1)) begin
        m[p] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [7:0] group_mask(input logic [7:0][3:0] ord,
                                            input logic [3:0] cnt);
    logic [7:0] m;
    m = '0;
    for (int k = 0; k < NPORT; k++) begin
      if (4'(k) < cnt) begin
        m = m | port_mask(ord[k]);
      end
    end
    return m;
  endfunction

  function automatic logic [7:0] port_gain(input logic [7:0][7:0] pg,
                                           input logic [3:0] code);
    logic [7:0] v;
    v = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (code == 4'(p + 1)) begin
        v = pg[p];
      end
    end
    return v;
  endfunction

  // ==========================================================
  // next state
  logic        wr_go;
  logic        ctrl_hit;
  logic        cmd_start;
  logic        cmd_stop;
  logic        ant_mode;
  logic        prev_on;
  logic        tg;
  logic [31:0] mw;
  logic [31:0] rd;
  logic        rd_ok;

  assign wr_go    = r.aw_ok && r.w_ok;
  assign ctrl_hit = wr_go && (r.waddr & ADDR_MASK) == ADDR_CTRL
                    && r.wstrb[0];
  assign cmd_start = ctrl_hit && r.wdata[CTRL_START];
  assign cmd_stop  = ctrl_hit && r.wdata[CTRL_STOP];
  assign ant_mode  = r.ant_prio && r.use_sw;
  assign prev_on   = r.prev_en && !r.ant_prio
                     && (has_master(r.master[0])
                         || has_master(r.master[1]));
  assign tmr_start = (r.st == ST_SETUP);

  always_comb begin
    n = r;
    tg = r.ftab[r.fi][FT_AC];
    mw = '0;
    rd = '0;
    rd_ok = 1'b1;
    n.rec = (r.st == ST_DWELL) && det_valid_i;
    // ----- write channel
    if (awvalid_i && awready_o) begin
      n.aw_ok = 1'b1;
      n.waddr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      n.w_ok = 1'b1;
      n.wdata = wdata_i;
      n.wstrb = wstrb_i;
    end
    if (r.bvalid && bready_i) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (r.waddr & ADDR_MASK)
        ADDR_CTRL: begin
          if (ctrl_hit && r.wdata[CTRL_PRIO]) begin
            n.ant_prio = !r.ant_prio;
          end
          if (ctrl_hit && r.wdata[CTRL_PREV]) begin
            n.prev_en = !r.prev_en;
          end
        end
        ADDR_STAT: begin
        end
        ADDR_CFG: begin
          mw = wmerge({26'h0, r.fcnt, r.use_sw}, r.wdata, r.wstrb);
          n.use_sw = mw[CFG_SW];
          n.fcnt = mw[CFG_CNT_HI:CFG_CNT_LO];
        end
        ADDR_MAST: begin
          mw = wmerge({24'h0, r.master}, r.wdata, r.wstrb);
          n.master = mw[7:0];
        end
        ADDR_STIME: begin
          mw = wmerge({16'h0, r.stime}, r.wdata, r.wstrb);
          n.stime = mw[15:0];
        end
        ADDR_GCNT: begin
          mw = wmerge({24'h0, r.gcnt}, r.wdata, r.wstrb);
          n.gcnt = mw[7:0];
        end
        ADDR_ORD_R: n.order[0] = wmerge(r.order[0], r.wdata, r.wstrb);
        ADDR_ORD_H: n.order[1] = wmerge(r.order[1], r.wdata, r.wstrb);
        ADDR_GN_LO: n.pgain[3:0] = wmerge(r.pgain[3:0], r.wdata,
                                          r.wstrb);
        ADDR_GN_HI: n.pgain[7:4] = wmerge(r.pgain[7:4], r.wdata,
                                          r.wstrb);
        ADDR_GN_X: begin
          mw = wmerge({8'h0, r.xgain}, r.wdata, r.wstrb);
          n.xgain = mw[23:0];
        end
        ADDR_FTAB: n.ftab = wmerge(r.ftab, r.wdata, r.wstrb);
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // ----- read channel
    unique case (araddr_i & ADDR_MASK)
      ADDR_CTRL:  rd = '0;
      ADDR_STAT:  rd = {19'h0, r.ap, r.mstep, r.g, r.fi, prev_on,
                        r.prev_en, r.ant_prio, (r.st != ST_IDLE)};
      ADDR_CFG:   rd = {26'h0, r.fcnt, r.use_sw};
      ADDR_MAST:  rd = {24'h0, r.master};
      ADDR_STIME: rd = {16'h0, r.stime};
      ADDR_GCNT:  rd = {24'h0, r.gcnt};
      ADDR_ORD_R: rd = r.order[0];
      ADDR_ORD_H: rd = r.order[1];
      ADDR_GN_LO: rd = r.pgain[3:0];
      ADDR_GN_HI: rd = r.pgain[7:4];
      ADDR_GN_X:  rd = {8'h0, r.xgain};
      ADDR_FTAB:  rd = r.ftab;
      default:    rd_ok = 1'b0;
    endcase
    if (r.rvalid && rready_i) begin
      n.rvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // ----- scan sequencer
    unique case (r.st)
      ST_IDLE: begin
      end
      ST_CHECK: begin
        if (!ant_mode) begin
          n.g = tg;
          if (r.fresh) begin
            n.mstep = r.use_sw && has_master(r.master[tg]);
            n.ap = '0;
            n.fresh = 1'b0;
          end
        end
        if (r.ftab[r.fi][FT_EN] && 5'(r.fi) < r.fcnt
            && (!r.use_sw || (tg == n.g && r.gcnt[n.g] != '0))) begin
          n.st = ST_SETUP;
        end else if (ant_mode) begin
          if (5'(r.fi) + 5'h01 >= r.fcnt) begin
            n.fi = '0;
            if (r.mstep) begin
              n.mstep = 1'b0;
            end else if (4'(r.ap) + 4'h1 < r.gcnt[r.g]) begin
              n.ap = r.ap + 3'h1;
            end else begin
              n.g = !r.g;
              n.ap = '0;
              n.mstep = has_master(r.master[!r.g]);
            end
          end else begin
            n.fi = r.fi + 4'h1;
          end
        end else begin
          n.fi = (5'(r.fi) + 5'h01 >= r.fcnt) ? 4'h0
                 : r.fi + 4'h1;
          n.fresh = 1'b1;
        end
      end
      ST_SETUP: begin
        n.det_seen = 1'b0;
        n.fout = r.fi;
        n.dwell = 1'b1;
        n.st = ST_DWELL;
        if (!r.use_sw) begin
          n.front = 1'b1;
          n.sel = '0;
          n.gain = r.xgain[0];
        end else if (r.mstep) begin
          n.front = 1'b0;
          n.gain = r.xgain[2'(r.g) + 2'h1];
          n.sel = (r.master[r.g] == MASTER_ALL)
                  ? group_mask(r.order[r.g], r.gcnt[r.g])
                  : port_mask(r.master[r.g]);
        end else begin
          n.front = 1'b0;
          n.sel = port_mask(r.order[r.g][r.ap]);
          n.gain = (r.master[r.g] == MASTER_ALL)
                   ? r.xgain[2'(r.g) + 2'h1]
                   : port_gain(r.pgain, r.order[r.g][r.ap]);
        end
      end
      ST_DWELL: begin
        if (det_valid_i) begin
          n.det_seen = 1'b1;
        end
        if (tmr_done) begin
          n.dwell = 1'b0;
          n.st = ST_CHECK;
          if (ant_mode) begin
            n.fi = r.fi;
            if (5'(r.fi) + 5'h01 >= r.fcnt) begin
              n.fi = '0;
              if (r.mstep) begin
                n.mstep = 1'b0;
              end else if (4'(r.ap) + 4'h1 < r.gcnt[r.g]) begin
                n.ap = r.ap + 3'h1;
              end else begin
                n.g = !r.g;
                n.ap = '0;
                n.mstep = has_master(r.master[!r.g]);
              end
            end else begin
              n.fi = r.fi + 4'h1;
            end
          end else if (r.mstep && !(prev_on && !r.det_seen)) begin
            n.mstep = 1'b0;
            n.ap = '0;
          end else if (!r.mstep && r.use_sw
                       && 4'(r.ap) + 4'h1 < r.gcnt[r.g]) begin
            n.ap = r.ap + 3'h1;
          end else begin
            n.fi = (5'(r.fi) + 5'h01 >= r.fcnt) ? 4'h0
                   : r.fi + 4'h1;
            n.fresh = 1'b1;
          end
        end
      end
    endcase
    // ----- start, mode change and stop
    if (cmd_start || ((n.ant_prio != r.ant_prio) && r.st != ST_IDLE)) begin
      n.st = ST_CHECK;
      n.fi = '0;
      n.fresh = 1'b1;
      n.g = 1'b0;
      n.ap = '0;
      n.mstep = has_master(r.master[0]);
      n.dwell = 1'b0;
    end
    if (cmd_stop || mem_full_i || power_fail_i) begin
      n.st = ST_IDLE;
      n.dwell = 1'b0;
      n.sel = '0;
      n.front = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.master <= {MASTER_NONE, MASTER_NONE};
      r.stime <= STIME_RST;
      r.pgain <= {NPORT{GAIN_RST}};
      r.xgain <= {3{GAIN_RST}};
      r.ftab <= '0;
      r.ant_prio <= 1'b0;
      r.st <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  ascan_dwell_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .start_i (tmr_start),
    .ms_i    (r.stime),
    .done_o  (tmr_done)
  );

  // ==========================================================
  // outputs
  assign awready_o = !r.aw_ok && !r.bvalid;
  assign wready_o  = !r.w_ok && !r.bvalid;
  assign bvalid_o  = r.bvalid;
  assign bresp_o   = r.bresp;
  assign arready_o = !r.rvalid;
  assign rvalid_o  = r.rvalid;
  assign rdata_o   = r.rdata;
  assign rresp_o   = r.rresp;
  assign switch_sel_o = r.sel;
  assign front_panel_antenna_input_o = r.front;
  assign gain_o     = r.gain;
  assign freq_idx_o = r.fout;
  assign dwell_o    = r.dwell;
  assign record_o   = r.rec;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_setup;
    r.st == ST_SETUP && tmr_start
      && !ctrl_hit && !mem_full_i && !power_fail_i;
  endsequence
  sequence s_dwell_on;
    dwell_o && r.st == ST_DWELL;
  endsequence

  property p_gain_then_timer;
    s_setup |=> s_dwell_on;
  endproperty
  a_gain_then_timer: assert property (p_gain_then_timer)
    else $error("dwell did not follow setup");

  property p_skip_disabled;
    r.st == ST_SETUP |-> r.ftab[r.fi][FT_EN];
  endproperty
  a_skip_disabled: assert property (p_skip_disabled)
    else $error("dwell on a disabled frequency");

  property p_preview_off;
    r.ant_prio |-> !prev_on;
  endproperty
  a_preview_off: assert property (p_preview_off)
    else $error("preview active under antenna priority");

  property p_prio_toggle;
    ctrl_hit && r.wdata[CTRL_PRIO] |=> r.ant_prio != $past(r.ant_prio);
  endproperty
  a_prio_toggle: assert property (p_prio_toggle)
    else $error("priority command did not toggle");

  property p_prev_toggle;
    ctrl_hit && r.wdata[CTRL_PREV] |=> r.prev_en != $past(r.prev_en);
  endproperty
  a_prev_toggle: assert property (p_prev_toggle)
    else $error("preview command did not toggle");

  property p_record;
    r.st == ST_DWELL && det_valid_i |=> record_o;
  endproperty
  a_record: assert property (p_record)
    else $error("detection not passed on");

  property p_group_sel;
    r.st == ST_SETUP && r.use_sw && r.mstep
      && r.master[r.g] == MASTER_ALL
      && !ctrl_hit && !mem_full_i && !power_fail_i
      |=> switch_sel_o == group_mask(r.order[r.g], r.gcnt[r.g]);
  endproperty
  a_group_sel: assert property (p_group_sel)
    else $error("whole group not selected");

  property p_group_gain;
    r.st == ST_SETUP && r.use_sw && r.master[r.g] == MASTER_ALL
      |=> gain_o == r.xgain[2'(r.g) + 2'h1];
  endproperty
  a_group_gain: assert property (p_group_gain)
    else $error("group master gain not applied");

  property p_stop;
    mem_full_i || power_fail_i |=> r.st == ST_IDLE ##1 !dwell_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("scan kept running after stop condition");
endmodule

/* File: verification/ascan_swbox_model.sv */
// switch box summer model with one transmitter behind it
`timescale 1ns/100ps
module ascan_swbox_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] switch_sel_i,
  input  wire logic       dwell_i,
  input  wire logic [3:0] freq_idx_i,
  input  wire logic [7:0] tx_ports_i,
  input  wire logic [3:0] tx_freq_i,
  output logic            det_valid_o = 1'h0
);
  logic [2:0] age = 3'h0;
  // ==========
  // one detection per dwell when a transmitting port is summed
  always @(posedge clock_i) begin
    age <= dwell_i ? age + 3'h1 : 3'h0;
    det_valid_o <= dwell_i && age == 3'h1 && freq_idx_i == tx_freq_i &&
      (switch_sel_i & tx_ports_i) != 8'h00;
  end
endmodule

/* File: verification/testbench.sv */
// self-checking testbench of the antenna scan sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
$display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench
  import ascan_pkg::*;
;
  // ==========
  // signals
  logic        clock_i = 1'h0, nrst_i = 1'h0;
  logic [7:0]  awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [3:0]  wstrb_i = 4'hF, freq_idx_o;
  logic        awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0;
  logic        arvalid_i = 1'h0, rready_i = 1'h0, det_valid_i;
  logic        mem_full_i = 1'h0, power_fail_i = 1'h0, dwl = 1'h0;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic        front_panel_antenna_input_o, dwell_o, record_o;
  logic [1:0]  bresp_o, rresp_o, lb;
  logic [7:0]  switch_sel_o, gain_o, g [0:10];
  logic [7:0]  rs [0:2] = '{8'h08, 8'h08, 8'h40};
  int          ri [0:2] = '{9, 3, 6};
  logic [20:0] expq [$];
  logic [20:0] got, cur;
  int          n_errors = 0, total_checks = 0, cyc = 0, nd = 0, nr = 0;
  int          seed = 30174;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  assign cur = {front_panel_antenna_input_o, freq_idx_o, switch_sel_o,
                gain_o};
  initial forever #2.5 clock_i = ~clock_i;
  ascan_sequencer #(.TICK_CYCLES(4)) dut (.clock_i, .nrst_i, .awaddr_i,
    .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o,
    .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
    .rdata_o, .rresp_o, .rvalid_o, .rready_i, .det_valid_i, .mem_full_i,
    .power_fail_i, .switch_sel_o, .front_panel_antenna_input_o, .gain_o,
    .freq_idx_o, .dwell_o, .record_o);
  ascan_swbox_model box (.clock_i, .switch_sel_i(switch_sel_o),
    .dwell_i(dwell_o), .freq_idx_i(freq_idx_o), .tx_ports_i(8'h40),
    .tx_freq_i(4'h0), .det_valid_o(det_valid_i));
  // ==========
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'h1;
    wvalid_i <= 1'h1;
    bready_i <= 1'h1;
    do begin
      @(posedge clock_i);
      if (awready_o) awvalid_i <= 1'h0;
      if (wready_o) wvalid_i <= 1'h0;
    end while (!bvalid_o);
    lb = bresp_o;
    bready_i <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [1:0] r,
      input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_i);
    araddr_i <= a;
    arvalid_i <= 1'h1;
    rready_i <= 1'h1;
    do begin
      @(posedge clock_i);
      if (arready_o) arvalid_i <= 1'h0;
    end while (!rvalid_o);
    rready_i <= 1'h0;
    `CHK({rresp_o, rdata_o & m}, {r, e})
  endtask
  // ==========
  // expected dwells
  task automatic ex(input int f, input logic [7:0] s, input logic [7:0] gn);
    expq.push_back({s == 8'h00, f[3:0], s, gn});
  endtask
  task automatic tail;
    ex(2, 8'h80, g[10]);
    ex(2, 8'h10, g[4]);
    ex(2, 8'h80, g[7]);
    ex(0, 8'h08, g[9]);
  endtask
  task automatic halt;
    while (expq.size() > 0) @(posedge clock_i);
    wr(ADDR_CTRL, 32'h2);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // output monitor
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    dwl <= dwell_o;
    if (det_valid_i && dwell_o) nd <= nd + 1;
    if (record_o) nr <= nr + 1;
    if (dwell_o && !dwl && expq.size() > 0) begin
      got = expq.pop_front();
      `CHK(cur, got)
    end
    if (cyc == 30000) begin
      n_errors++;
      conclude();
    end
  end
  // ==========
  // main sequence
  initial begin
    for (int i = 0; i < 11; i++) g[i] = 8'($random(seed));
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'h1;
    rdc(ADDR_STAT, RESP_OKAY, 32'hF, 32'h0);
    rdc(ADDR_MAST, RESP_OKAY, 32'hFF, 32'h99);
    rdc(ADDR_GN_LO, RESP_OKAY, ALL, 32'h32323232);
    rdc(8'h40, RESP_SLVERR, ALL, 32'h0);
    wr(8'h40, 32'h1);
    `CHK(lb, RESP_SLVERR)
    wr(ADDR_STIME, 32'h1);
    wr(ADDR_CFG, 32'h9);
    wr(ADDR_GCNT, 32'h22);
    wr(ADDR_ORD_R, 32'h74);
    wr(ADDR_ORD_H, 32'h85);
    wr(ADDR_MAST, 32'h84);
    wr(ADDR_FTAB, 32'h35);
    wr(ADDR_GN_LO, {g[3], g[2], g[1], g[0]});
    wr(ADDR_GN_HI, {g[7], g[6], g[5], g[4]});
    wr(ADDR_GN_X, {8'h00, g[10], g[9], g[8]});
    rdc(ADDR_GN_HI, RESP_OKAY, ALL, {g[7], g[6], g[5], g[4]});
    for (int f = 0; f < 2; f++)
      for (int a = 0; a < 3; a++) ex(f, rs[a], g[ri[a]]);
    tail();
    wr(ADDR_CTRL, 32'h1);
    halt();
    wr(ADDR_CTRL, 32'hC);
    rdc(ADDR_STAT, RESP_OKAY, 32'hE, 32'h6);
    for (int a = 0; a < 3; a++)
      for (int f = 0; f < 2; f++) ex(f, rs[a], g[ri[a]]);
    tail();
    wr(ADDR_CTRL, 32'h1);
    halt();
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_MAST, 32'h90);
    ex(0, 8'h48, g[9]);
    ex(0, 8'h08, g[9]);
    ex(0, 8'h40, g[9]);
    ex(1, 8'h48, g[9]);
    ex(2, 8'h10, g[4]);
    ex(2, 8'h80, g[7]);
    ex(0, 8'h48, g[9]);
    wr(ADDR_CTRL, 32'h1);
    halt();
    `CHK(nr, nd)
    wr(ADDR_CFG, 32'h8);
    for (int f = 0; f < 4; f++) ex(f % 3, 8'h00, g[8]);
    wr(ADDR_CTRL, 32'h1);
    halt();
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, 32'h1);
      repeat (20) @(posedge clock_i);
      rdc(ADDR_STAT, RESP_OKAY, 32'h1, 32'h1);
      {power_fail_i, mem_full_i} <= 2'h1 << i;
      @(posedge clock_i);
      {power_fail_i, mem_full_i} <= 2'h0;
      rdc(ADDR_STAT, RESP_OKAY, 32'h1, 32'h0);
      `CHK(dwell_o, 1'h0)
    end
    conclude();
  end
endmodule
